// ---- src/adc_regs_pkg.sv ----
// Constants shared by the converter status and result register block.
// Assumes a 32-bit register bus with word-aligned offsets.
package adc_regs_pkg;
   localparam int NUM_CHAN = 8;
   localparam int RES_W = 10;
   localparam int FLAG_W = 20;
   // Byte offsets of the register map
   localparam logic [7:0] OFF_CHAN_ENABLE_SET = 8'h10;
   localparam logic [7:0] OFF_CHAN_ENABLE_CLEAR = 8'h14;
   localparam logic [7:0] OFF_CHANNEL_ENABLE_VIEW = 8'h18;
   localparam logic [7:0] OFF_CONVERSION_STATUS = 8'h1C;
   localparam logic [7:0] OFF_LAST_RESULT = 8'h20;
   localparam logic [7:0] OFF_IRQ_ENABLE_SET = 8'h24;
   localparam logic [7:0] OFF_IRQ_ENABLE_CLEAR = 8'h28;
   localparam logic [7:0] OFF_IRQ_MASK_VIEW = 8'h2C;
   localparam logic [7:0] OFF_CHANNEL_RESULT0 = 8'h30;
   localparam logic [7:0] OFF_CHANNEL_RESULT7 = 8'h4C;
   localparam logic [7:0] OFF_DMA_RX_COUNTER = 8'h60;
   localparam logic [7:0] OFF_DMA_RX_NEXT_COUNTER = 8'h64;
   // Status field positions
   localparam int POS_DONE = 0;
   localparam int POS_OVR = 8;
   localparam int POS_READY = 16;
   localparam int POS_GOVR = 17;
   localparam int POS_RX_COUNT_DONE_FLAG = 18;
   localparam int POS_BOTHEMPTY = 19;
   localparam int CNT_W = 16;
   localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage : adc_regs_pkg

// ---- src/ahb_reg_port.sv ----
// AHB-Lite slave front end: captures the address phase, yields one-cycle
// write and read strobes in the data phase. Zero wait states, OKAY always.
`timescale 1ns/100ps
`default_nettype none
module ahb_reg_port (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic wr_stb,
   output logic rd_stb,
   output logic [7:0] reg_addr
);
   import adc_regs_pkg::*;

   logic phase_valid;
   logic phase_write;
   // Latch a word-sized NONSEQ address phase
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         phase_valid <= 1'b0;
         phase_write <= 1'b0;
         reg_addr <= 8'h00;
      end else if (hready) begin
         phase_valid <= hsel && htrans == HTRANS_NONSEQ && hsize == HSIZE_WORD;
         phase_write <= hwrite;
         reg_addr <= haddr[7:0];
      end
   end
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign wr_stb = phase_valid && phase_write;
   assign rd_stb = phase_valid && !phase_write;
endmodule : ahb_reg_port
`default_nettype wire

// ---- src/set_clear_flags.sv ----
// Bank of sticky flags: set wins over clear in the same cycle.
// Assumes set and clear come from logic on core_clk.
`timescale 1ns/100ps
`default_nettype none
module set_clear_flags #(
   parameter int WIDTH = 8
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic soft_clear,
   input wire logic [WIDTH-1:0] set,
   input wire logic [WIDTH-1:0] clear,
   output logic [WIDTH-1:0] flags
);
   // One flop per flag, set has priority so no event is lost
   for (genvar i = 0; i < WIDTH; i++) begin : g_flag
      always_ff @(posedge core_clk or negedge rstn) begin
         if (!rstn) begin
            flags[i] <= 1'b0;
         end else if (set[i]) begin
            flags[i] <= 1'b1;
         end else if (clear[i] || soft_clear) begin
            flags[i] <= 1'b0;
         end
      end
   end
endmodule : set_clear_flags
`default_nettype wire

// ---- src/adc_status_interrupt_regs.sv ----
// Status, result and interrupt-mask registers of an eight-channel converter.
// Assumes conv_done pulses one core_clk cycle from converter logic on the same clock.
// Summary of operation
// - Done flag set on enabled channel completion
// - Done flag zero if disabled or pending
// - Channel overrun sets flag, status read clears
// - Ready flag set on result, cleared reading
// - General overrun sticky, status read clears
// - Counter reaching zero sets flag, write clears
// - Both-empty flag while both counters zero
// - Last result loaded on every completion
// - Channel result loaded only when enabled
// - Enable-set ones set mask bits
// - Enable-clear ones clear mask bits
// - Mask view returns current mask
// - Channel enable view reports enable state
//
// Our own choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
module adc_status_interrupt_regs #(
   parameter int CHANS = adc_regs_pkg::NUM_CHAN
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic soft_reset,
   input wire logic conv_done,
   input wire logic [2:0] conv_chan,
   input wire logic [adc_regs_pkg::RES_W-1:0] conv_value,
   input wire logic dma_rx_decrement,
   output logic irq
);
   import adc_regs_pkg::*;

   if (CHANS != NUM_CHAN) begin : g_bad_chans
      $error("CHANS must equal eight: status layout is fixed");
   end

   logic wr_stb;
   logic rd_stb;
   logic [7:0] reg_addr;
   logic [CHANS-1:0] chan_enabled;
   logic [FLAG_W-1:0] irq_mask;
   logic [RES_W-1:0] last_result_value;
   logic [RES_W-1:0] per_channel_result [CHANS];
   logic [CNT_W-1:0] dma_rx_counter;
   logic [CNT_W-1:0] dma_rx_next_counter;
   logic [CHANS-1:0] conv_done_flag;
   logic [CHANS-1:0] chan_overrun_flag;
   logic [1:0] glob_flags;
   logic result_ready_flag;
   logic global_overrun_flag;
   logic rx_count_done_flag;
   logic rx_both_empty_flag;
   logic [FLAG_W-1:0] status_word;
   logic [CHANS-1:0] done_set;
   logic [CHANS-1:0] done_clr;
   logic [CHANS-1:0] ovr_set;
   logic status_rd;
   logic last_rd;
   logic cnt_wr;
   logic rx_reach;
   logic [31:0] next_rdata;

   // Decoded write to a given offset
   function automatic logic wr_to(input logic [7:0] off);
      return wr_stb && reg_addr == off;
   endfunction : wr_to

   ahb_reg_port u_port (
      .core_clk(core_clk),
      .rstn(rstn),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hready(hready),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .wr_stb(wr_stb),
      .rd_stb(rd_stb),
      .reg_addr(reg_addr)
   );

   // Channel enable bits, software reset returns them to zero
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         chan_enabled <= '0;
      end else if (soft_reset) begin
         chan_enabled <= '0;
      end else if (wr_to(OFF_CHAN_ENABLE_SET)) begin
         chan_enabled <= chan_enabled | hwdata[CHANS-1:0];
      end else if (wr_to(OFF_CHAN_ENABLE_CLEAR)) begin
         chan_enabled <= chan_enabled & ~hwdata[CHANS-1:0];
      end
   end

   // Interrupt mask, write-one-to-set and write-one-to-clear
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         irq_mask <= '0;
      end else if (soft_reset) begin
         irq_mask <= '0;
      end else if (wr_to(OFF_IRQ_ENABLE_SET)) begin
         irq_mask <= irq_mask | hwdata[FLAG_W-1:0];
      end else if (wr_to(OFF_IRQ_ENABLE_CLEAR)) begin
         irq_mask <= irq_mask & ~hwdata[FLAG_W-1:0];
      end
   end

   // Last result follows every completion
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         last_result_value <= '0;
      end else if (soft_reset) begin
         last_result_value <= '0;
      end else if (conv_done) begin
         last_result_value <= conv_value;
      end
   end

   // Per-channel results only for enabled channels
   for (genvar c = 0; c < CHANS; c++) begin : g_chan
      always_ff @(posedge core_clk or negedge rstn) begin
         if (!rstn) begin
            per_channel_result[c] <= '0;
         end else if (soft_reset) begin
            per_channel_result[c] <= '0;
         end else if (conv_done && conv_chan == 3'(c) && chan_enabled[c]) begin
            per_channel_result[c] <= conv_value;
         end
      end
      assign done_set[c] = conv_done && conv_chan == 3'(c) && chan_enabled[c];
      assign ovr_set[c] = done_set[c] && conv_done_flag[c];
      // Reading this channel's result consumes its done flag
      assign done_clr[c] = rd_stb && reg_addr == OFF_CHANNEL_RESULT0 + 8'(4 * c);
   end

   assign status_rd = rd_stb && reg_addr == OFF_CONVERSION_STATUS;
   assign last_rd = rd_stb && reg_addr == OFF_LAST_RESULT;
   assign cnt_wr = wr_to(OFF_DMA_RX_COUNTER) || wr_to(OFF_DMA_RX_NEXT_COUNTER);
   // decrement that empties the current buffer; one coinciding with a counter write is dropped
   assign rx_reach = dma_rx_decrement && dma_rx_counter == CNT_W'(1) && !cnt_wr;

   set_clear_flags #(.WIDTH(CHANS)) u_done (
      .core_clk(core_clk),
      .rstn(rstn),
      .soft_clear(soft_reset),
      .set(done_set),
      .clear(done_clr),
      .flags(conv_done_flag)
   );

   set_clear_flags #(.WIDTH(CHANS)) u_ovr (
      .core_clk(core_clk),
      .rstn(rstn),
      .soft_clear(soft_reset),
      .set(ovr_set),
      .clear({CHANS{status_rd}}),
      .flags(chan_overrun_flag)
   );

   // ready set on result, general overrun
   set_clear_flags #(.WIDTH(2)) u_glob (
      .core_clk(core_clk),
      .rstn(rstn),
      .soft_clear(soft_reset),
      .set({conv_done && result_ready_flag, conv_done}),
      .clear({status_rd, last_rd}),
      .flags(glob_flags)
   );
   assign result_ready_flag = glob_flags[0];
   assign global_overrun_flag = glob_flags[1];

   // Receive counters: software loads, the transfer engine decrements
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         dma_rx_counter <= '0;
         dma_rx_next_counter <= '0;
      end else if (soft_reset) begin
         dma_rx_counter <= '0;
         dma_rx_next_counter <= '0;
      end else if (wr_to(OFF_DMA_RX_COUNTER)) begin
         dma_rx_counter <= hwdata[CNT_W-1:0];
      end else if (wr_to(OFF_DMA_RX_NEXT_COUNTER)) begin
         dma_rx_next_counter <= hwdata[CNT_W-1:0];
      end else if (dma_rx_decrement && dma_rx_counter != '0) begin
         if (dma_rx_counter == CNT_W'(1)) begin
            // Reload from the next counter as the buffer swaps
            dma_rx_counter <= dma_rx_next_counter;
            dma_rx_next_counter <= '0;
         end else begin
            dma_rx_counter <= dma_rx_counter - CNT_W'(1);
         end
      end
   end

   // sticky zero-reach, any counter write clears
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rx_count_done_flag <= 1'b1;
      end else if (soft_reset) begin
         rx_count_done_flag <= 1'b1;
      end else if (rx_reach) begin
         rx_count_done_flag <= 1'b1;
      end else if (cnt_wr) begin
         rx_count_done_flag <= 1'b0;
      end
   end

   assign rx_both_empty_flag = dma_rx_counter == '0 && dma_rx_next_counter == '0;

   // done bits only from enabled channels
   assign status_word = {rx_both_empty_flag, rx_count_done_flag, global_overrun_flag,
                         result_ready_flag, chan_overrun_flag, conv_done_flag & chan_enabled};

   assign irq = |(status_word & irq_mask);

   // Read mux; unmapped and write-only offsets read zero
   always_comb begin
      next_rdata = RESET_ZERO;
      case (reg_addr)
         OFF_CHANNEL_ENABLE_VIEW: next_rdata[CHANS-1:0] = chan_enabled; // enable view
         OFF_CONVERSION_STATUS: next_rdata[FLAG_W-1:0] = status_word;
         OFF_LAST_RESULT: next_rdata[RES_W-1:0] = last_result_value;
         OFF_IRQ_MASK_VIEW: next_rdata[FLAG_W-1:0] = irq_mask; // mask view
         OFF_DMA_RX_COUNTER: next_rdata[CNT_W-1:0] = dma_rx_counter;
         OFF_DMA_RX_NEXT_COUNTER: next_rdata[CNT_W-1:0] = dma_rx_next_counter;
         default: begin
            if (reg_addr >= OFF_CHANNEL_RESULT0 && reg_addr <= OFF_CHANNEL_RESULT7 && reg_addr[1:0] == 2'h0) begin
               next_rdata[RES_W-1:0] = per_channel_result[3'(reg_addr[4:2] - OFF_CHANNEL_RESULT0[4:2])];
            end
         end
      endcase
   end

   // Read data is combinational off the registered address phase; zero when idle
   assign hrdata = rd_stb ? next_rdata : RESET_ZERO;

   // Checks
   ready_set_a: assert property (@(posedge core_clk) disable iff (!rstn)
      conv_done && !soft_reset |=> result_ready_flag) else $error("ready flag not set");
   ready_clear_a: assert property (@(posedge core_clk) disable iff (!rstn)
      last_rd && !conv_done |=> !result_ready_flag) else $error("ready flag not cleared");
   govr_set_a: assert property (@(posedge core_clk) disable iff (!rstn)
      conv_done && result_ready_flag && !soft_reset |=> global_overrun_flag) else $error("overrun missed");
   last_load_a: assert property (@(posedge core_clk) disable iff (!rstn)
      conv_done && !soft_reset |=> last_result_value == $past(conv_value)) else $error("last result wrong");
   empty_level_a: assert property (@(posedge core_clk) disable iff (!rstn)
      status_word[POS_BOTHEMPTY] == (dma_rx_counter == '0 && dma_rx_next_counter == '0))
      else $error("both-empty flag wrong");
   rx_count_done_flag_clear_a: assert property (@(posedge core_clk) disable iff (!rstn)
      cnt_wr && !soft_reset |=> !rx_count_done_flag) else $error("rx_count_done_flag not cleared");
   done_gate_a: assert property (@(posedge core_clk) disable iff (!rstn)
      (status_word[CHANS-1:0] & ~chan_enabled) == '0) else $error("done flag on disabled channel");
   mask_set_a: assert property (@(posedge core_clk) disable iff (!rstn)
      wr_to(OFF_IRQ_ENABLE_SET) && !soft_reset |=> (irq_mask & $past(hwdata[FLAG_W-1:0])) == $past(hwdata[FLAG_W-1:0]))
      else $error("mask not set");
   mask_clear_a: assert property (@(posedge core_clk) disable iff (!rstn)
      wr_to(OFF_IRQ_ENABLE_CLEAR) |=> (irq_mask & $past(hwdata[FLAG_W-1:0])) == '0) else $error("mask not cleared");
   irq_out_a: assert property (@(posedge core_clk) disable iff (!rstn)
      irq == |(status_word & irq_mask)) else $error("interrupt output wrong");
   ovr_clear_a: assert property (@(posedge core_clk) disable iff (!rstn)
      status_rd && ovr_set == '0 |=> chan_overrun_flag == '0) else $error("overrun not cleared");
   // Set, load and clear paths that the level checks above do not reach
   done_set_a: assert property (@(posedge core_clk) disable iff (!rstn)
      conv_done && chan_enabled[conv_chan] && !soft_reset |=> conv_done_flag[$past(conv_chan)])
      else $error("done flag not set");
   chan_load_a: assert property (@(posedge core_clk) disable iff (!rstn)
      conv_done && chan_enabled[conv_chan] && !soft_reset |=> per_channel_result[$past(conv_chan)] == $past(conv_value))
      else $error("channel result not loaded");
   chan_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
      conv_done && !chan_enabled[conv_chan] && !soft_reset |=>
      per_channel_result[$past(conv_chan)] == $past(per_channel_result[conv_chan])) else $error("disabled channel loaded");
   chan_ovr_a: assert property (@(posedge core_clk) disable iff (!rstn)
      conv_done && chan_enabled[conv_chan] && conv_done_flag[conv_chan] && !soft_reset |=>
      chan_overrun_flag[$past(conv_chan)]) else $error("channel overrun missed");
   govr_clear_a: assert property (@(posedge core_clk) disable iff (!rstn)
      status_rd && !(conv_done && result_ready_flag) |=> !global_overrun_flag)
      else $error("general overrun not cleared");
   rx_count_done_flag_set_a: assert property (@(posedge core_clk) disable iff (!rstn)
      rx_reach && !soft_reset |=> rx_count_done_flag)
      else $error("rx_count_done_flag not set");
   enable_set_a: assert property (@(posedge core_clk) disable iff (!rstn)
      wr_to(OFF_CHAN_ENABLE_SET) && !soft_reset |=> (chan_enabled & $past(hwdata[CHANS-1:0])) == $past(hwdata[CHANS-1:0]))
      else $error("channel not enabled");
endmodule : adc_status_interrupt_regs
`default_nettype wire

// ---- sim/adc_status_interrupt_regs_tb.sv ----
// Self-checking bench for the converter status, result and interrupt-mask registers.
// Assumes the register package is compiled first; the bench is the only AHB-Lite master.
`timescale 1ns/100ps
`default_nettype none
module adc_status_interrupt_regs_tb;
   import adc_regs_pkg::*;

   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h0;
   logic [31:0] hwdata = 32'h0000_0000;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   logic soft_reset = 1'b0;
   logic conv_done = 1'b0;
   logic [2:0] conv_chan = 3'h0;
   logic [RES_W-1:0] conv_value = '0;
   logic dma_rx_decrement = 1'b0;
   logic irq;
   int n_fail = 0;
   int checks = 0;

   // Single slave, so its ready is the bus ready
   adc_status_interrupt_regs uut (
      .core_clk(core_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .soft_reset(soft_reset),
      .conv_done(conv_done), .conv_chan(conv_chan), .conv_value(conv_value),
      .dma_rx_decrement(dma_rx_decrement), .irq(irq)
   );

   // 125 MHz clock
   initial begin
      forever #4 core_clk = ~core_clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : stop_test

   // Bounded wait for an edge with ready high, so a stuck slave ends the run
   task automatic wait_ready();
      int n;
      n = 0;
      @(posedge core_clk);
      while (hreadyout !== 1'b1) begin
         n++;
         if (n > 50) begin
            n_fail++;
            $display("CHECK FAILED at %0t: bus ready never came", $time);
            stop_test();
         end
         @(posedge core_clk);
      end
   endtask : wait_ready

   // One single word transfer; entered just after a rising edge
   task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                       output logic [31:0] rdata);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, addr};
      htrans <= HTRANS_NONSEQ;
      hwrite <= wr;
      hsize <= HSIZE_WORD;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wr ? wdata : 32'h0000_0000;
      wait_ready();
      rdata = hrdata;
   endtask : xfer

   task automatic wr(input logic [7:0] addr, input logic [31:0] data);
      logic [31:0] r;
      xfer(1'b1, addr, data, r);
   endtask : wr

   task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
      logic [31:0] r;
      xfer(1'b0, addr, 32'h0000_0000, r);
      check(r, exp);
   endtask : rd_chk

   // One-cycle completion pulse, then a quiet cycle so pulses never merge
   task automatic conv(input logic [2:0] ch, input logic [RES_W-1:0] v);
      conv_done <= 1'b1;
      conv_chan <= ch;
      conv_value <= v;
      @(posedge core_clk);
      conv_done <= 1'b0;
      @(posedge core_clk);
   endtask : conv

   task automatic pulse_dec();
      dma_rx_decrement <= 1'b1;
      @(posedge core_clk);
      dma_rx_decrement <= 1'b0;
      @(posedge core_clk);
   endtask : pulse_dec

   // Main sequence
   initial begin
      repeat (20) @(posedge core_clk);
      rstn <= 1'b1;
      @(posedge core_clk);
      check({31'h0000_0000, irq}, 32'h0000_0000);
      check({31'h0000_0000, hresp}, 32'h0000_0000);
      rd_chk(OFF_CONVERSION_STATUS, 32'h000C_0000);
      rd_chk(OFF_IRQ_MASK_VIEW, 32'h0000_0000);
      rd_chk(OFF_LAST_RESULT, 32'h0000_0000);
      rd_chk(OFF_CHANNEL_ENABLE_VIEW, 32'h0000_0000);
      rd_chk(8'h50, 32'h0000_0000);
      // Completion on a disabled channel: last result and ready flag only
      conv(3'h2, 10'h155);
      rd_chk(OFF_CONVERSION_STATUS, 32'h000D_0000);
      rd_chk(OFF_CHANNEL_RESULT0 + 8'h08, 32'h0000_0000);
      rd_chk(OFF_LAST_RESULT, 32'h0000_0155);
      rd_chk(OFF_CONVERSION_STATUS, 32'h000C_0000);
      // Enable view follows set and clear writes
      wr(OFF_CHAN_ENABLE_SET, 32'h0000_0005);
      rd_chk(OFF_CHANNEL_ENABLE_VIEW, 32'h0000_0005);
      // enable-clear write disables channel 2, channel 0 stays enabled
      wr(OFF_CHAN_ENABLE_CLEAR, 32'h0000_0004);
      rd_chk(OFF_CHANNEL_ENABLE_VIEW, 32'h0000_0001);
      // Two completions on channel 0 with no result read between them
      conv(3'h0, 10'h3FF);
      rd_chk(OFF_CONVERSION_STATUS, 32'h000D_0001);
      conv(3'h0, 10'h2AA);
      rd_chk(OFF_CONVERSION_STATUS, 32'h000F_0101);
      rd_chk(OFF_CONVERSION_STATUS, 32'h000D_0001);
      rd_chk(OFF_CHANNEL_RESULT0, 32'h0000_02AA);
      rd_chk(OFF_CONVERSION_STATUS, 32'h000D_0000);
      rd_chk(OFF_LAST_RESULT, 32'h0000_02AA);
      // Mask set and clear; zeros leave other bits alone
      wr(OFF_IRQ_ENABLE_SET, 32'h0000_0003);
      rd_chk(OFF_IRQ_MASK_VIEW, 32'h0000_0003);
      wr(OFF_IRQ_ENABLE_SET, 32'h0001_0000);
      rd_chk(OFF_IRQ_MASK_VIEW, 32'h0001_0003);
      wr(OFF_IRQ_ENABLE_CLEAR, 32'h0000_0001);
      rd_chk(OFF_IRQ_MASK_VIEW, 32'h0001_0002);
      check({31'h0000_0000, irq}, 32'h0000_0000);
      conv(3'h1, 10'h011);
      check({31'h0000_0000, irq}, 32'h0000_0001);
      wr(OFF_IRQ_ENABLE_CLEAR, 32'h0001_0000);
      rd_chk(OFF_IRQ_MASK_VIEW, 32'h0000_0002);
      check({31'h0000_0000, irq}, 32'h0000_0000);
      rd_chk(OFF_LAST_RESULT, 32'h0000_0011);
      // Receive counters: write clears, reaching zero sets
      wr(OFF_DMA_RX_COUNTER, 32'h0000_0002);
      rd_chk(OFF_CONVERSION_STATUS, 32'h0000_0000);
      pulse_dec();
      rd_chk(OFF_CONVERSION_STATUS, 32'h0000_0000);
      pulse_dec();
      rd_chk(OFF_CONVERSION_STATUS, 32'h000C_0000);
      wr(OFF_DMA_RX_NEXT_COUNTER, 32'h0000_0001);
      rd_chk(OFF_CONVERSION_STATUS, 32'h0000_0000);
      // Buffer swap: the counter ends its run and the next count moves in
      wr(OFF_DMA_RX_COUNTER, 32'h0000_0001);
      pulse_dec();
      rd_chk(OFF_CONVERSION_STATUS, 32'h0004_0000);
      rd_chk(OFF_DMA_RX_COUNTER, 32'h0000_0001);
      rd_chk(OFF_DMA_RX_NEXT_COUNTER, 32'h0000_0000);
      // Software reset returns everything to reset values
      conv(3'h0, 10'h0AB);
      soft_reset <= 1'b1;
      @(posedge core_clk);
      soft_reset <= 1'b0;
      @(posedge core_clk);
      rd_chk(OFF_CONVERSION_STATUS, 32'h000C_0000);
      rd_chk(OFF_IRQ_MASK_VIEW, 32'h0000_0000);
      rd_chk(OFF_CHANNEL_ENABLE_VIEW, 32'h0000_0000);
      rd_chk(OFF_LAST_RESULT, 32'h0000_0000);
      rd_chk(OFF_CHANNEL_RESULT0, 32'h0000_0000);
      stop_test();
   end
endmodule : adc_status_interrupt_regs_tb
`default_nettype wire
